/* File: logic/pio_defines.vh */
// Register offsets, field positions and reset values for the port block.
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH
`define PIO_OFF_A_LATCH 8'h01
`define PIO_OFF_B_LATCH 8'h02
`define PIO_OFF_C_LATCH 8'h03
`define PIO_OFF_C_TYPE 8'h04
`define PIO_OFF_D_LATCH 8'h05
`define PIO_OFF_A_PIN 8'h08
`define PIO_OFF_B_PIN 8'h09
`define PIO_OFF_C_PIN 8'h0a
`define PIO_OFF_D_PIN 8'h0b
`define PIO_OFF_A_SEG 8'h29
`define PIO_OFF_D_SEG 8'h2a
`define PIO_OFF_CTRL 8'h30
`define PIO_CTRL_DUAL_BIT 0
`define PIO_CTRL_GLOBAL_OUTPUT_ENABLE_BIT 1
`define PIO_CTRL_STOP_BIT 2
`define PIO_RST_A_LATCH 8'hff
`define PIO_RST_B_LATCH 3'h7
`define PIO_RST_C_LATCH 4'hf
`define PIO_RST_C_TYPE 4'h0
`define PIO_RST_D_LATCH 8'hff
`define PIO_RST_SEG 8'h00
`define PIO_RST_CTRL 3'h2
`define PIO_B_OSC_IN_BIT 1
`define PIO_B_OSC_OUT_BIT 2
`define PIO_B_STOP_BIT 0
`endif

/* File: logic/pio_sync.v */
// Two-stage synchroniser for a bus of pin levels.
`timescale 1ns/1ps
module pio_sync #(
   parameter W = 8
) (
   input wire clk,
   input wire rst,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
reg [W-1:0] meta_r;
always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
   end
   else
   begin
      meta_r <= d;
      q <= meta_r;
   end
end
endmodule // pio_sync

/* File: logic/pio_ports.v */
// Parallel ports A to D with an Avalon-MM register slave.
// Function
// [RULE_01] Output latches hold until rewritten.
// [RULE_02] Pins sampled at read, not latched.
// [RULE_03] Write updates latch and pin next.
// [RULE_04] Port A segment select routes segment.
// [RULE_05] Software: port A input needs latch 1.
// [RULE_06] Port A latch resets to ones.
// [RULE_07] Separate latch and pin read addresses.
// [RULE_08] Segment bits read pin undefined.
// [RULE_09] Port B three bits, resets ones.
// [RULE_10] Dual clock: B1, B2 oscillator pins.
// [RULE_11] B0 output falling edge sets interrupt.
// [RULE_12] Port B upper bits read undefined.
// [RULE_13] Stop mode floats B0 always.
// [RULE_14] Port C type: 0 drain, 1 push-pull.
// [RULE_15] Port C latch ones, type zeros.
// [RULE_16] Software: C peripheral output needs latch 1.
// [RULE_17] Software: C input latch 1, type 0.
// [RULE_18] Port C upper bits read undefined.
// [RULE_19] Port D latch resets to ones.
// [RULE_20] Port D segment select picks source.
// [RULE_21] Software: port D input needs latch 1.
// [RULE_22] Latch 1 releases open-drain pin.
`timescale 1ns/1ps
`include "pio_defines.vh"
module pio_ports (
   input wire clk,
   input wire rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire [7:0] port_a_in,
   output wire [7:0] port_a_out,
   output wire [7:0] port_a_oe,
   input wire [2:0] port_b_in,
   output wire [2:0] port_b_out,
   output wire [2:0] port_b_oe,
   input wire [3:0] port_c_in,
   output wire [3:0] port_c_out,
   output wire [3:0] port_c_oe,
   input wire [7:0] port_d_in,
   output wire [7:0] port_d_out,
   output wire [7:0] port_d_oe,
   input wire [7:0] seg_a,
   input wire [7:0] seg_d,
   input wire [3:0] periph_c_out,
   input wire low_freq_osc_out,
   output wire low_freq_osc_in,
   output reg stop_release_irq
);
////////////////////////////////////////////////////////////////////////////////
reg [7:0] port_a_out_latch_r;
reg [7:0] port_a_segment_select_r;
reg [2:0] port_b_out_latch_r;
reg [3:0] port_c_out_latch_r;
reg [3:0] port_c_output_type_r;
reg [7:0] port_d_out_latch_r;
reg [7:0] port_d_segment_select_r;
reg [2:0] ctrl_r;
reg [1:0] bus_state_r;
reg [1:0] bus_state_nxt;
reg b0_prev_r;
wire [7:0] a_pin_s;
wire [2:0] b_pin_s;
wire [3:0] c_pin_s;
wire [7:0] d_pin_s;
wire wr_en;
wire rd_en;
wire dual_clk;
wire global_output_enable;
wire stop_mode;
wire [3:0] c_drive;
wire b0_drive;
reg [31:0] rd_nxt;
wire bus_req;
wire bus_ack;
wire wr_a_latch;
wire wr_a_seg;
wire wr_b_latch;
wire wr_c_latch;
wire wr_c_type;
wire wr_d_latch;
wire wr_d_seg;
wire wr_ctrl;

////////////////////////////////////////////////////////////////////////////////
// Bus handshake states, one-hot.
localparam [1:0] BUS_IDLE = 2'b01;
localparam [1:0] BUS_ACK = 2'b10;

////////////////////////////////////////////////////////////////////////////////
// Address match, shared by the write strobes.
function reg_hit;
   input [7:0] adr;
   input [7:0] off;
   begin
      reg_hit = (adr == off);
   end
endfunction

// Segment value on selected bits, latch value on the others.
function [7:0] seg_mux_out;
   input [7:0] sel;
   input [7:0] seg;
   input [7:0] latch;
   begin
      seg_mux_out = (sel & seg) | (~sel & latch);
   end
endfunction

// With en set, segment bits always drive, latch bits drive only a 0.
function [7:0] seg_mux_oe;
   input en;
   input [7:0] sel;
   input [7:0] latch;
   begin
      seg_mux_oe = {8{en}} & (sel | ~latch);
   end
endfunction

// Pins pass two flip-flops before the read mux sees them.
pio_sync #(.W(23)) u_sync (
   .clk(clk),
   .rst(rst),
   .d({port_a_in, port_b_in, port_c_in, port_d_in}),
   .q({a_pin_s, b_pin_s, c_pin_s, d_pin_s})
);

////////////////////////////////////////////////////////////////////////////////
// One wait cycle: the access completes on the second edge.
assign bus_req = avs_read | avs_write;
assign bus_ack = bus_state_r[1];
assign avs_waitrequest = bus_req & ~bus_ack;
assign wr_en = avs_write & bus_ack;
assign rd_en = avs_read & ~bus_ack;
assign dual_clk = ctrl_r[`PIO_CTRL_DUAL_BIT];
assign global_output_enable = ctrl_r[`PIO_CTRL_GLOBAL_OUTPUT_ENABLE_BIT];
assign stop_mode = ctrl_r[`PIO_CTRL_STOP_BIT];

// A request seen in the idle state is answered in the next cycle.
always @*
begin
   case (bus_state_r)
      BUS_IDLE:
      begin
         if (bus_req)
            bus_state_nxt = BUS_ACK;
         else
            bus_state_nxt = BUS_IDLE;
      end
      BUS_ACK:
         bus_state_nxt = BUS_IDLE;
      default:
         bus_state_nxt = BUS_IDLE;
   endcase
end

always @(posedge clk or posedge rst)
begin
   if (rst)
      bus_state_r <= BUS_IDLE;
   else
      bus_state_r <= bus_state_nxt;
end

// Each register has its own write strobe.
assign wr_a_latch = wr_en & reg_hit(avs_address, `PIO_OFF_A_LATCH);
assign wr_a_seg = wr_en & reg_hit(avs_address, `PIO_OFF_A_SEG);
assign wr_b_latch = wr_en & reg_hit(avs_address, `PIO_OFF_B_LATCH);
assign wr_c_latch = wr_en & reg_hit(avs_address, `PIO_OFF_C_LATCH);
assign wr_c_type = wr_en & reg_hit(avs_address, `PIO_OFF_C_TYPE);
assign wr_d_latch = wr_en & reg_hit(avs_address, `PIO_OFF_D_LATCH);
assign wr_d_seg = wr_en & reg_hit(avs_address, `PIO_OFF_D_SEG);
assign wr_ctrl = wr_en & reg_hit(avs_address, `PIO_OFF_CTRL);

////////////////////////////////////////////////////////////////////////////////
// Latches change only on an accepted write.
always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      port_a_out_latch_r <= `PIO_RST_A_LATCH; // [RULE_06]
   end
   else if (wr_a_latch)
   begin
      port_a_out_latch_r <= avs_writedata[7:0]; // [RULE_01] [RULE_03]
   end
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      port_a_segment_select_r <= `PIO_RST_SEG;
   end
   else if (wr_a_seg)
   begin
      port_a_segment_select_r <= avs_writedata[7:0]; // [RULE_04]
   end
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      port_b_out_latch_r <= `PIO_RST_B_LATCH; // [RULE_09]
   end
   else if (wr_b_latch)
   begin
      port_b_out_latch_r <= avs_writedata[2:0]; // [RULE_01] [RULE_03]
   end
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      port_c_out_latch_r <= `PIO_RST_C_LATCH; // [RULE_15]
   end
   else if (wr_c_latch)
   begin
      port_c_out_latch_r <= avs_writedata[3:0]; // [RULE_01] [RULE_03]
   end
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      port_c_output_type_r <= `PIO_RST_C_TYPE; // [RULE_15]
   end
   else if (wr_c_type)
   begin
      port_c_output_type_r <= avs_writedata[3:0]; // [RULE_14]
   end
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      port_d_out_latch_r <= `PIO_RST_D_LATCH; // [RULE_19]
   end
   else if (wr_d_latch)
   begin
      port_d_out_latch_r <= avs_writedata[7:0]; // [RULE_01] [RULE_03]
   end
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      port_d_segment_select_r <= `PIO_RST_SEG;
   end
   else if (wr_d_seg)
   begin
      port_d_segment_select_r <= avs_writedata[7:0]; // [RULE_20]
   end
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      ctrl_r <= `PIO_RST_CTRL;
   end
   else if (wr_ctrl)
   begin
      ctrl_r <= avs_writedata[2:0];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read data is sampled at the first cycle of the access.
always @*
begin
   rd_nxt = 32'h0000_0000;
   case (avs_address) // [RULE_07]
      `PIO_OFF_A_LATCH: rd_nxt[7:0] = port_a_out_latch_r;
      `PIO_OFF_A_SEG: rd_nxt[7:0] = port_a_segment_select_r;
      `PIO_OFF_B_LATCH: rd_nxt[2:0] = port_b_out_latch_r; // [RULE_12]
      `PIO_OFF_C_LATCH: rd_nxt[3:0] = port_c_out_latch_r; // [RULE_18]
      `PIO_OFF_C_TYPE: rd_nxt[3:0] = port_c_output_type_r;
      `PIO_OFF_D_LATCH: rd_nxt[7:0] = port_d_out_latch_r;
      `PIO_OFF_D_SEG: rd_nxt[7:0] = port_d_segment_select_r;
      `PIO_OFF_CTRL: rd_nxt[2:0] = ctrl_r;
      `PIO_OFF_A_PIN: rd_nxt[7:0] = a_pin_s; // [RULE_02] [RULE_08]
      `PIO_OFF_B_PIN: rd_nxt[2:0] = b_pin_s; // [RULE_02] [RULE_12]
      `PIO_OFF_C_PIN: rd_nxt[3:0] = c_pin_s; // [RULE_02] [RULE_18]
      `PIO_OFF_D_PIN: rd_nxt[7:0] = d_pin_s; // [RULE_02] [RULE_08]
      default: rd_nxt = 32'h0000_0000;
   endcase
end

always @(posedge clk or posedge rst)
begin
   if (rst)
      avs_readdata <= 32'h0000_0000;
   else if (rd_en)
      avs_readdata <= rd_nxt; // [RULE_02]
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers. A 1 in the latch floats open-drain pins so input reads work.
assign port_a_out = seg_mux_out(port_a_segment_select_r, seg_a,
   port_a_out_latch_r); // [RULE_04]
assign port_a_oe = seg_mux_oe(global_output_enable, port_a_segment_select_r,
   port_a_out_latch_r); // [RULE_04] [RULE_22]

assign port_d_out = seg_mux_out(port_d_segment_select_r, seg_d,
   port_d_out_latch_r); // [RULE_20]
assign port_d_oe = seg_mux_oe(global_output_enable, port_d_segment_select_r,
   port_d_out_latch_r); // [RULE_20] [RULE_22]

assign c_drive = port_c_out_latch_r & periph_c_out;
assign port_c_out = c_drive;
assign port_c_oe = {4{global_output_enable}}
   & (port_c_output_type_r | ~c_drive); // [RULE_14] [RULE_22]

assign port_b_out[0] = port_b_out_latch_r[0];
assign port_b_oe[0] = global_output_enable & ~stop_mode
   & ~port_b_out_latch_r[0]; // [RULE_13] [RULE_22]
assign port_b_out[1] = port_b_out_latch_r[1];
assign port_b_oe[1] = global_output_enable & ~dual_clk
   & ~port_b_out_latch_r[1]; // [RULE_10]
assign port_b_out[2] = dual_clk ? low_freq_osc_out
   : port_b_out_latch_r[2]; // [RULE_10]
assign port_b_oe[2] = dual_clk | (global_output_enable
   & ~port_b_out_latch_r[2]); // [RULE_10]
assign low_freq_osc_in = dual_clk & b_pin_s[`PIO_B_OSC_IN_BIT]; // [RULE_10]

////////////////////////////////////////////////////////////////////////////////
// Falling edge of the synchronised B0 level, driven or external, raises a pulse.
assign b0_drive = b_pin_s[`PIO_B_STOP_BIT];
always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      // Start low, since the synchroniser shows zeros just after reset.
      b0_prev_r <= 1'b0;
      stop_release_irq <= 1'b0;
   end
   else
   begin
      b0_prev_r <= b0_drive;
      stop_release_irq <= b0_prev_r & ~b0_drive; // [RULE_11]
   end
end
endmodule // pio_ports

/* File: verif/pio_pins.sv */
// Board model of one port: released bits show the board level.
`timescale 1ns/1ps
module pio_pins #(
   parameter W = 8
) (
   input wire [W-1:0] drv,
   input wire [W-1:0] oe,
   input wire [W-1:0] ext,
   output wire [W-1:0] pin
);
   assign pin = (oe & drv) | (~oe & ext);
endmodule // pio_pins

/* File: verif/pio_props.sv */
// Concurrent checks on the port block bus, pin enables after reset and wake pulse.
`timescale 1ns/1ps
module pio_props (
   input wire clk,
   input wire rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire [2:0] port_b_in,
   input wire [7:0] port_a_oe,
   input wire [3:0] port_c_oe,
   input wire stop_release_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire [7:0] a = avs_address;
   wire ok = avs_read && !avs_waitrequest;
   wire map = a inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09,
      8'h0a, 8'h0b, 8'h29, 8'h2a, 8'h30};
   AST_RST_OE: assert property
      ($fell(rst) |-> port_a_oe == 8'h00 && port_c_oe == 4'h0)
      else $error("pins driven after reset");
   AST_WAIT_FIRST: assert property
      ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
      else $error("no wait in first cycle");
   AST_WAIT_ONE: assert property
      ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait too long");
   AST_UNMAPPED: assert property
      (ok && !map |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_B_UPPER: assert property
      (ok && (a == 8'h02 || a == 8'h09) |-> avs_readdata[31:3] == 29'h0)
      else $error("port b upper bits set");
   AST_C_UPPER: assert property
      (ok && a inside {8'h03, 8'h04, 8'h0a} |-> avs_readdata[31:4] == 28'h0)
      else $error("port c upper bits set");
   AST_IRQ_EDGE: assert property
      ($fell(port_b_in[0]) |-> ##[1:4] stop_release_irq)
      else $error("no pulse on falling pin");
   AST_IRQ_ONE: assert property
      (stop_release_irq |=> !stop_release_irq)
      else $error("pulse too long");
endmodule // pio_props
bind pio_ports pio_props u_props (.clk, .rst, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .port_b_in, .port_a_oe,
   .port_c_oe, .stop_release_irq);

/* File: verif/pio_ports_tb.sv */
// Self-checking bench for the parallel port block.
`timescale 1ns/1ps
module pio_ports_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wreq, lf_in;
   logic [7:0] pa_i, pa_o, pa_e, pd_i, pd_o, pd_e;
   logic [2:0] pb_i, pb_o, pb_e;
   logic [3:0] pc_i, pc_o, pc_e;
   logic irq;
   logic osc = 1'b1;
   logic [7:0] seg_a = 8'h3c, seg_d = 8'ha5, ext_a = 8'h0f, ext_d = 8'hff;
   logic [3:0] periph = 4'hf, ext_c = 4'h2;
   logic [2:0] ext_b = 3'h7;
   int irq_cnt = 0;
   int failures = 0;
   int cmp_count = 0;
   logic [7:0] ra [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h29, 8'h2a,
      8'h30, 8'h00};
   logic [7:0] rv [9] = '{8'hff, 8'h07, 8'h0f, 8'h00, 8'hff, 8'h00, 8'h00,
      8'h02, 8'h00};
   always #5 clk = ~clk;
   pio_ports u_dut (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .port_a_in(pa_i), .port_a_out(pa_o),
      .port_a_oe(pa_e), .port_b_in(pb_i), .port_b_out(pb_o), .port_b_oe(pb_e),
      .port_c_in(pc_i), .port_c_out(pc_o), .port_c_oe(pc_e), .port_d_in(pd_i),
      .port_d_out(pd_o), .port_d_oe(pd_e), .seg_a(seg_a), .seg_d(seg_d),
      .periph_c_out(periph), .low_freq_osc_out(osc), .low_freq_osc_in(lf_in),
      .stop_release_irq(irq));
   pio_pins #(.W(8)) u_pa (.drv(pa_o), .oe(pa_e), .ext(ext_a), .pin(pa_i));
   pio_pins #(.W(3)) u_pb (.drv(pb_o), .oe(pb_e), .ext(ext_b), .pin(pb_i));
   pio_pins #(.W(4)) u_pc (.drv(pc_o), .oe(pc_e), .ext(ext_c), .pin(pc_i));
   pio_pins #(.W(8)) u_pd (.drv(pd_o), .oe(pd_e), .ext(ext_d), .pin(pd_i));
   always @(posedge clk)
      if (irq === 1'b1)
         irq_cnt <= irq_cnt + 1;
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task io(input logic w, input logic [7:0] ad, input logic [7:0] d,
      input logic [7:0] e, input logic [7:0] m);
      addr <= ad;
      wdata <= {24'h0, d};
      rd <= !w;
      wr <= w;
      do
         @(posedge clk);
      while (wreq !== 1'b0);
      if (!w)
         chk(rdata & {24'h0, m}, {24'h0, e});
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task results;
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 9; i++)
         io(1'b0, ra[i], 8'h00, rv[i], 8'hff);
      io(1'b1, 8'h01, 8'h5a, 8'h00, 8'h00);
      io(1'b0, 8'h01, 8'h00, 8'h5a, 8'hff);
      io(1'b0, 8'h08, 8'h00, 8'h0a, 8'hff);
      ext_a <= 8'hf0;
      repeat (2) @(posedge clk);
      io(1'b0, 8'h08, 8'h00, 8'h50, 8'hff);
      io(1'b1, 8'h29, 8'hf0, 8'h00, 8'h00);
      chk({24'h0, pa_o & 8'hf0}, 32'h30);
      seg_a <= 8'hc3;
      @(posedge clk);
      chk({24'h0, pa_o & 8'hf0}, 32'hc0);
      io(1'b1, 8'h05, 8'h33, 8'h00, 8'h00);
      io(1'b1, 8'h2a, 8'h0f, 8'h00, 8'h00);
      chk({24'h0, pd_o & 8'h0f}, 32'h05);
      io(1'b0, 8'h0b, 8'h00, 8'h30, 8'hf0);
      io(1'b1, 8'h03, 8'h05, 8'h00, 8'h00);
      io(1'b1, 8'h04, 8'h0c, 8'h00, 8'h00);
      io(1'b0, 8'h04, 8'h00, 8'h0c, 8'hff);
      io(1'b0, 8'h0a, 8'h00, 8'h04, 8'hff);
      periph <= 4'hb;
      @(posedge clk);
      chk({28'h0, pc_o}, 32'h1);
      chk(irq_cnt, 32'h0);
      io(1'b1, 8'h02, 8'h06, 8'h00, 8'h00);
      io(1'b0, 8'h02, 8'h00, 8'h06, 8'hff);
      io(1'b0, 8'h09, 8'h00, 8'h06, 8'hff);
      chk(irq_cnt, 32'h1);
      io(1'b1, 8'h30, 8'h06, 8'h00, 8'h00);
      chk({31'h0, pb_e[0]}, 32'h0);
      io(1'b1, 8'h30, 8'h03, 8'h00, 8'h00);
      chk({28'h0, pb_e[2:1], pb_o[2], lf_in}, 32'hb);
      osc <= 1'b0;
      @(posedge clk);
      chk({31'h0, pb_o[2]}, 32'h0);
      results;
   end
   initial
   begin
      #100000;
      failures++;
      results;
   end
endmodule // pio_ports_tb
